// *** rtl/tbo_pkg.sv ***
// Purpose: shared constants for the break and burst block
// Assumes: 16-bit registers on a byte-addressed register port
// Notes: offsets are byte addresses
package tbo_pkg;

  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_BDT = 8'h44;
  localparam logic [7:0] ADDR_DCTRL = 8'h48;
  localparam logic [7:0] ADDR_BURST = 8'h4C;

  // break_deadtime_control fields
  localparam int DTS_LSB = 0;
  localparam int LOCK_LSB = 8;
  localparam int BIT_IDLE_OFF = 10;
  localparam int BIT_RUN_OFF = 11;
  localparam int BIT_BREAK_EN = 12;
  localparam int BIT_BREAK_POL = 13;
  localparam int BIT_AUTO_OE = 14;
  localparam int BIT_MAIN_OE = 15;

  // dma_burst_control fields
  localparam int BASE_LSB = 0;
  localparam int LEN_LSB = 8;
  localparam logic [15:0] DCTRL_MASK = 16'h1F1F;

  // lock levels
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_ONE = 2'h1;

  // reset values
  localparam logic [15:0] BDT_RESET = 16'h0000;
  localparam logic [15:0] DCTRL_RESET = 16'h0000;
  localparam logic BREAK_LEVEL_RESET = 1'b1;

endpackage : tbo_pkg

// *** rtl/tbo_fifo.sv ***
// Purpose: small first-in first-out buffer with valid and ready
// Assumes: DEPTH is a power of two
// Notes: ready on the fill side drops when full
`timescale 1ns/1ps
module tbo_fifo #(
  parameter int WIDTH = tbo_pkg::DATA_W,
  parameter int DEPTH = tbo_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic rdy;
  } tbo_fifo_state_t;

  tbo_fifo_state_t st_reg;
  tbo_fifo_state_t st_next;
  logic push;
  logic pop;

  assign in_ready_o = st_reg.rdy;
  assign out_valid_o = (st_reg.count != '0);
  assign out_data_o = st_reg.mem[st_reg.rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data_i;
      st_next.wr_ptr = PW'(st_reg.wr_ptr + 1'b1);
    end
    if (pop) begin
      st_next.rd_ptr = PW'(st_reg.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      st_next.count = CW'(st_reg.count + 1'b1);
    end else if (pop && !push) begin
      st_next.count = CW'(st_reg.count - 1'b1);
    end
    // ready is kept in a flop so the fill side sees a registered signal
    st_next.rdy = (st_next.count != CW'(DEPTH));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '{rdy: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : tbo_fifo

// *** rtl/tbo_break_burst.sv ***
// Purpose: main output enable with break, and burst register access
// Assumes: one 25 MHz clock, synchronous active-low reset
// Notes: dma byte mode must not change inside a burst
//
// How it works
// [RULE_01] run off-state 1: a newly enabled channel first drives inactive level
// [RULE_02] break input acts only while break enable is 1
// [RULE_03] break polarity 0 means low active, 1 means high active
// [RULE_04] software waits one clock before trusting a new polarity
// [RULE_05] auto enable sets main enable at update when no break
// [RULE_06] main enable 0 disables outputs or forces idle level
// [RULE_07] with main enable 1, each output drives only when enabled
// [RULE_08] an active break clears main enable at once
// [RULE_09] lock level 1 or more freezes break enable, polarity, auto enable
// [RULE_10] burst base counts registers from control register one
// [RULE_11] burst length field plus one gives transfers per burst
// [RULE_12] burst data access goes to base plus running index
// [RULE_13] 16-bit data puts one word into each target register
// [RULE_14] 8-bit data puts high byte first, low byte next
// [RULE_15] lock field encodes levels and is written once after reset
// [RULE_16] target byte address is control one plus four times sum
// [RULE_17] burst control reserved bits read zero, writes ignored
`timescale 1ns/1ps
module tbo_break_burst (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic break_input_i,
  input wire logic update_event_i,
  input wire logic [3:0] channel_output_enable_i,
  input wire logic [3:0] channel_complement_enable_i,
  input wire logic [3:0] channel_polarity_i,
  input wire logic [3:0] complement_polarity_i,
  input wire logic [3:0] pwm_ref_i,
  input wire logic dma_wvalid_i,
  input wire logic [15:0] dma_wdata_i,
  input wire logic dma_byte_mode_i,
  output logic dma_wready_o,
  output logic [3:0] channel_output_o,
  output logic [3:0] channel_output_oe_n_o,
  output logic [3:0] channel_complement_output_o,
  output logic [3:0] channel_complement_oe_n_o,
  output logic main_output_enable_o
);

  typedef struct packed {
    logic [7:0] dts;
    logic [1:0] lock;
    logic lock_done;
    logic idle_off;
    logic run_off;
    logic brk_en;
    logic brk_pol;
    logic auto_oe;
    logic moe;
    logic [4:0] base;
    logic [4:0] blen;
    logic [4:0] idx;
    logic half;
    logic [2:0] brk_s;
    logic brk_lvl;
    logic [3:0] en_d;
    logic [3:0] enn_d;
    logic [3:0] out;
    logic [3:0] oe_n;
    logic [3:0] outn;
    logic [3:0] oen_n;
    logic [15:0] rdata;
  } tbo_state_t;

  localparam tbo_state_t ST_RST = '{
    brk_s: {3{tbo_pkg::BREAK_LEVEL_RESET}},
    brk_lvl: tbo_pkg::BREAK_LEVEL_RESET,
    oe_n: 4'hF,
    oen_n: 4'hF,
    default: '0
  };

  tbo_state_t st_reg;
  tbo_state_t st_next;

  logic fifo_valid;
  logic fifo_pop;
  logic [15:0] fifo_data;
  logic brk_act;
  logic [5:0] tgt_sum;
  logic [7:0] tgt_addr;
  logic [15:0] bdt_val;
  logic [15:0] dctrl_val;
  logic burst_rd;
  logic drain_go;

  ////////////////////////////////////////////////////////////////
  // write data for the burst stream
  tbo_fifo #(
    .WIDTH(tbo_pkg::DATA_W),
    .DEPTH(tbo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(dma_wvalid_i),
    .in_ready_o(dma_wready_o),
    .in_data_i(dma_wdata_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  ////////////////////////////////////////////////////////////////
  // break level and register views
  assign brk_act = st_reg.brk_en && (st_reg.brk_lvl == st_reg.brk_pol); // RULE_02 RULE_03
  assign tgt_sum = {1'b0, st_reg.base} + {1'b0, st_reg.idx}; // RULE_10 RULE_12
  assign tgt_addr = tbo_pkg::ADDR_CTRL_ONE + {tgt_sum, 2'b00}; // RULE_16
  assign bdt_val = {st_reg.moe, st_reg.auto_oe, st_reg.brk_pol, st_reg.brk_en,
                    st_reg.run_off, st_reg.idle_off, st_reg.lock, st_reg.dts};
  assign dctrl_val = {3'h0, st_reg.blen, 3'h0, st_reg.base}; // RULE_17
  assign burst_rd = reg_rd_i && (reg_addr_i == tbo_pkg::ADDR_BURST);
  assign drain_go = fifo_valid && !reg_wr_i && !burst_rd;
  assign fifo_pop = drain_go && (!dma_byte_mode_i || st_reg.half); // RULE_13 RULE_14

  ////////////////////////////////////////////////////////////////
  always_comb begin
    logic we;
    logic adv;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [15:0] wd;
    we = 1'b0;
    adv = 1'b0;
    wa = reg_addr_i;
    ra = reg_addr_i;
    wd = reg_wdata_i;
    st_next = st_reg;
    st_next.rdata = '0;

    // three-stage input filter on the break pin
    st_next.brk_s = {st_reg.brk_s[1:0], break_input_i};
    if (st_reg.brk_s[2] == st_reg.brk_s[1]) begin
      st_next.brk_lvl = st_reg.brk_s[2];
    end

    // one register write per cycle, software first
    if (reg_wr_i) begin
      we = 1'b1;
      if (reg_addr_i == tbo_pkg::ADDR_BURST) begin
        wa = tgt_addr; // RULE_12
        adv = 1'b1;
      end
    end else if (drain_go) begin
      we = 1'b1;
      wa = tgt_addr; // RULE_12
      adv = 1'b1;
      if (!dma_byte_mode_i) begin
        wd = fifo_data; // RULE_13
      end else if (!st_reg.half) begin
        wd = {8'h00, fifo_data[15:8]}; // RULE_14
      end else begin
        wd = {8'h00, fifo_data[7:0]}; // RULE_14
      end
      st_next.half = dma_byte_mode_i && !st_reg.half;
    end

    // burst read goes to the current target
    if (reg_rd_i) begin
      if (burst_rd) begin
        ra = tgt_addr; // RULE_12
        adv = 1'b1;
      end
      if (ra == tbo_pkg::ADDR_BDT) begin
        st_next.rdata = bdt_val;
      end else if (ra == tbo_pkg::ADDR_DCTRL) begin
        st_next.rdata = dctrl_val;
      end
    end

    // index wraps after length plus one beats
    if (adv) begin
      if (st_reg.idx == st_reg.blen) begin
        st_next.idx = '0; // RULE_11
      end else begin
        st_next.idx = 5'(st_reg.idx + 5'h01);
      end
    end

    if (we && wa == tbo_pkg::ADDR_BDT) begin
      st_next.moe = wd[tbo_pkg::BIT_MAIN_OE];
      if (st_reg.lock == tbo_pkg::LOCK_NONE) begin
        st_next.dts = wd[tbo_pkg::DTS_LSB +: 8];
        st_next.brk_en = wd[tbo_pkg::BIT_BREAK_EN]; // RULE_09
        st_next.brk_pol = wd[tbo_pkg::BIT_BREAK_POL]; // RULE_09
        st_next.auto_oe = wd[tbo_pkg::BIT_AUTO_OE]; // RULE_09
      end
      if (st_reg.lock <= tbo_pkg::LOCK_ONE) begin
        st_next.idle_off = wd[tbo_pkg::BIT_IDLE_OFF];
        st_next.run_off = wd[tbo_pkg::BIT_RUN_OFF];
      end
      if (!st_reg.lock_done) begin
        st_next.lock = wd[tbo_pkg::LOCK_LSB +: 2]; // RULE_15
        st_next.lock_done = 1'b1; // RULE_15
      end
    end else if (we && wa == tbo_pkg::ADDR_DCTRL) begin
      st_next.base = wd[tbo_pkg::BASE_LSB +: 5]; // RULE_10
      st_next.blen = wd[tbo_pkg::LEN_LSB +: 5]; // RULE_11
      st_next.idx = '0;
      st_next.half = 1'b0;
    end

    // automatic re-enable, then break wins over any set
    if (update_event_i && st_reg.auto_oe && !brk_act) begin
      st_next.moe = 1'b1; // RULE_05
    end
    if (brk_act) begin
      st_next.moe = 1'b0; // RULE_08
    end

    // output stage per channel
    st_next.en_d = channel_output_enable_i;
    st_next.enn_d = channel_complement_enable_i;
    for (int i = 0; i < tbo_pkg::NUM_CH; i++) begin
      st_next.oe_n[i] = 1'b1;
      st_next.oen_n[i] = 1'b1;
      st_next.out[i] = channel_polarity_i[i];
      st_next.outn[i] = complement_polarity_i[i];
      if (st_reg.moe) begin
        if (channel_output_enable_i[i]) begin // RULE_07
          if (st_reg.en_d[i]) begin
            st_next.oe_n[i] = 1'b0;
            st_next.out[i] = pwm_ref_i[i] ^ channel_polarity_i[i];
          end else begin
            st_next.oe_n[i] = !st_reg.run_off; // RULE_01
          end
        end
        if (channel_complement_enable_i[i]) begin // RULE_07
          if (st_reg.enn_d[i]) begin
            st_next.oen_n[i] = 1'b0;
            st_next.outn[i] = !pwm_ref_i[i] ^ complement_polarity_i[i];
          end else begin
            st_next.oen_n[i] = !st_reg.run_off; // RULE_01
          end
        end
      end else begin
        st_next.oe_n[i] = !(st_reg.idle_off && channel_output_enable_i[i]); // RULE_06
        st_next.oen_n[i] = !(st_reg.idle_off && channel_complement_enable_i[i]); // RULE_06
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign channel_output_o = st_reg.out;
  assign channel_output_oe_n_o = st_reg.oe_n;
  assign channel_complement_output_o = st_reg.outn;
  assign channel_complement_oe_n_o = st_reg.oen_n;
  assign main_output_enable_o = st_reg.moe;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_break_clears_main: assert property (brk_act |=> !st_reg.moe) // RULE_08
    else $error("break did not clear main enable");
  a_break_off_quiet: assert property (!st_reg.brk_en && st_reg.moe // RULE_02
    && !reg_wr_i && !drain_go |=> st_reg.moe)
    else $error("main enable dropped with break disabled");
  a_break_level_pol: assert property (st_reg.brk_en && st_reg.brk_pol && st_reg.brk_lvl // RULE_03
    |=> !st_reg.moe)
    else $error("break polarity not honoured");
  a_auto_sets_main: assert property (update_event_i && st_reg.auto_oe && !brk_act |=> st_reg.moe) // RULE_05
    else $error("auto enable missed update");
  a_no_auto_set: assert property (!st_reg.moe && !st_reg.auto_oe // RULE_05
    && !reg_wr_i && !drain_go |=> !st_reg.moe)
    else $error("main enable set without software");
  a_idle_disables: assert property (!st_reg.moe && !st_reg.idle_off |=> channel_output_oe_n_o == 4'hF) // RULE_06
    else $error("outputs driven while main enable off");
  a_drive_needs_en: assert property (!channel_output_enable_i[0] |=> channel_output_oe_n_o[0]) // RULE_07
    else $error("channel driven without enable");
  a_rise_inactive: assert property (st_reg.moe && st_reg.run_off && channel_output_enable_i[0]
    && !st_reg.en_d[0] |=> !channel_output_oe_n_o[0] // RULE_01
    && channel_output_o[0] == $past(channel_polarity_i[0]))
    else $error("new channel not at inactive level");
  a_lock_freezes: assert property (st_reg.lock != tbo_pkg::LOCK_NONE |=> $stable(st_reg.brk_en) // RULE_09
    && $stable(st_reg.brk_pol) && $stable(st_reg.auto_oe))
    else $error("locked bit changed");
  a_index_wraps: assert property (burst_rd && st_reg.idx == st_reg.blen |=> st_reg.idx == 5'h00) // RULE_11
    else $error("burst index did not wrap");
  a_reserved_zero: assert property (reg_rd_i && reg_addr_i == tbo_pkg::ADDR_DCTRL // RULE_17
    |=> reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[15:13] == 3'h0)
    else $error("reserved bits read nonzero");
  a_byte_two_beats: assert property (drain_go && dma_byte_mode_i && !st_reg.half // RULE_14
    |=> st_reg.half && $stable(fifo_data))
    else $error("byte datum popped after one beat");

  ////////////////////////////////////////////////////////////////
  // output stage checks on channel 0, complement idle check on all four
  a_comp_needs_en: assert property (!channel_complement_enable_i[0] |=> channel_complement_oe_n_o[0]) // RULE_07
    else $error("complement driven without enable");
  a_main_off_comp: assert property (!st_reg.moe && !st_reg.idle_off // RULE_06
    |=> channel_complement_oe_n_o == 4'hF)
    else $error("complements driven while main enable off");
  a_idle_drives_pol: assert property (!st_reg.moe && st_reg.idle_off && channel_output_enable_i[0] // RULE_06
    |=> !channel_output_oe_n_o[0] && channel_output_o[0] == $past(channel_polarity_i[0]))
    else $error("idle channel not at its polarity level");
  a_drive_follows_ref: assert property (st_reg.moe && channel_output_enable_i[0] && st_reg.en_d[0] // RULE_07
    |=> !channel_output_oe_n_o[0]
    && channel_output_o[0] == ($past(pwm_ref_i[0]) ^ $past(channel_polarity_i[0])))
    else $error("enabled channel not following reference");
  a_comp_follows_ref: assert property (st_reg.moe && channel_complement_enable_i[0] && st_reg.enn_d[0] // RULE_07
    |=> !channel_complement_oe_n_o[0]
    && channel_complement_output_o[0] == (!$past(pwm_ref_i[0]) ^ $past(complement_polarity_i[0])))
    else $error("enabled complement not following reference");

  // break, main enable and lock checks
  a_break_wins_update: assert property (brk_act && update_event_i |=> !st_reg.moe) // RULE_05
    else $error("update set main enable during break");
  a_sw_sets_main: assert property (reg_wr_i && reg_addr_i == tbo_pkg::ADDR_BDT // RULE_05
    && reg_wdata_i[tbo_pkg::BIT_MAIN_OE] && !brk_act |=> st_reg.moe)
    else $error("software set of main enable lost");
  a_filter_holds: assert property (st_reg.brk_s[2] != st_reg.brk_s[1] |=> $stable(st_reg.brk_lvl)) // RULE_02
    else $error("break level moved before stages agreed");
  a_lock_once: assert property (st_reg.lock_done |=> $stable(st_reg.lock)) // RULE_15
    else $error("lock field written twice");
  a_lock_keeps_dts: assert property (st_reg.lock != tbo_pkg::LOCK_NONE |=> $stable(st_reg.dts)) // RULE_09
    else $error("dead time changed under lock");

  // burst checks
  a_dctrl_clears_idx: assert property (reg_wr_i && reg_addr_i == tbo_pkg::ADDR_DCTRL // RULE_10
    |=> st_reg.idx == 5'h00 && !st_reg.half)
    else $error("burst control write kept old index");
  a_index_steps: assert property (drain_go && st_reg.idx != st_reg.blen // RULE_12
    |=> st_reg.idx == $past(st_reg.idx) + 5'h01)
    else $error("burst index did not advance");
  a_byte_phase_flips: assert property (drain_go && dma_byte_mode_i // RULE_14
    |=> st_reg.half != $past(st_reg.half))
    else $error("byte phase did not flip");
  a_dctrl_fields: assert property (reg_rd_i && reg_addr_i == tbo_pkg::ADDR_DCTRL // RULE_11
    |=> reg_rdata_o[tbo_pkg::LEN_LSB +: 5] == $past(st_reg.blen) && reg_rdata_o[tbo_pkg::BASE_LSB +: 5] == $past(st_reg.base))
    else $error("burst control fields misplaced");
  a_burst_reads_bdt: assert property (burst_rd && tgt_addr == tbo_pkg::ADDR_BDT // RULE_16
    |=> reg_rdata_o == $past(bdt_val))
    else $error("burst read missed its target");
  a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000) // RULE_17
    else $error("read data stood without a read");

endmodule : tbo_break_burst

// *** tb/tbo_dma_model.sv ***
// Purpose: dma write stream source and break pin source
// Assumes: words leave in the order pushed
// Notes: idle data line toggles so no stale word is seen
`timescale 1ns/1ps
module tbo_dma_model (
  input wire logic clk_i,
  input wire logic dma_wready_i,
  output logic dma_wvalid_o,
  output logic [15:0] dma_wdata_o,
  output logic break_input_o
);
  logic [15:0] words[$];
  logic slow = 1'b0;
  logic gap_q = 1'b0;
  initial begin
    dma_wvalid_o = 1'b0;
    dma_wdata_o = 16'h0000;
    break_input_o = 1'b1;
  end
  task automatic push(input logic [15:0] w);
    words.push_back(w);
  endtask : push
  task automatic set_brk(input logic v);
    break_input_o = v;
  endtask : set_brk
  ////////////////////////////////////////
  // a word and its valid hold until taken
  always @(posedge clk_i) begin
    gap_q <= slow & ~gap_q;
    if (dma_wvalid_o && dma_wready_i) begin
      void'(words.pop_front());
    end
    if (!dma_wvalid_o || dma_wready_i) begin
      if (words.size() != 0 && !gap_q) begin
        dma_wvalid_o <= 1'b1;
        dma_wdata_o <= words[0];
      end else begin
        dma_wvalid_o <= 1'b0;
        dma_wdata_o <= ~dma_wdata_o;
      end
    end
  end
endmodule : tbo_dma_model

// *** tb/tbo_break_burst_tb_top.sv ***
// Purpose: self-checking bench for break control and burst access
// Assumes: register model tracks lock and first write
// Notes: main enable expectations follow break and update events
`timescale 1ns/1ps
module tbo_break_burst_tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, upd = 1'b0, bmode = 1'b0;
  logic [3:0] en = 4'h0, cen = 4'h0, pol = 4'h0, cpol = 4'h0, ref4 = 4'h0, r;
  logic [15:0] rdata, ddata, m_bdt = 16'h0000;
  logic break_input, dvalid, dready, main;
  logic [3:0] out, oen, cout, coen;
  logic [31:0] rnd;
  bit m_used = 1'b0;
  int miscompares = 0, tests_run = 0;
  integer seed = 32'h0B0B40B1;
  always #20 clk_i = ~clk_i;
  tbo_break_burst i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .break_input_i(break_input), .update_event_i(upd),
    .channel_output_enable_i(en), .channel_complement_enable_i(cen), .channel_polarity_i(pol),
    .complement_polarity_i(cpol), .pwm_ref_i(ref4), .dma_wvalid_i(dvalid), .dma_wdata_i(ddata),
    .dma_byte_mode_i(bmode), .dma_wready_o(dready), .channel_output_o(out),
    .channel_output_oe_n_o(oen), .channel_complement_output_o(cout),
    .channel_complement_oe_n_o(coen), .main_output_enable_o(main));
  tbo_dma_model i_dma (.clk_i(clk_i), .dma_wready_i(dready), .dma_wvalid_o(dvalid),
    .dma_wdata_o(ddata), .break_input_o(break_input));
  ////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // model of a break_deadtime_control write under the lock
  function automatic void bdt_wr(input logic [15:0] d);
    logic [15:0] keep;
    keep = (m_bdt[9:8] != 2'h0) ? 16'h73FF : 16'h0300;
    if (!m_used) keep = 16'h0000;
    m_bdt = (m_bdt & keep) | (d & ~keep);
    m_used = 1'b1;
  endfunction : bdt_wr
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    #1;
    if (a == tbo_pkg::ADDR_BDT) bdt_wr(d);
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk
  task automatic do_reset;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    m_bdt = 16'h0000;
    m_used = 1'b0;
    cyc(1);
  endtask : do_reset
  task automatic drain;
    for (int i = 0; i < 200 && (i_dma.words.size() != 0 || dvalid); i++) cyc(1);
    cyc(4);
  endtask : drain
  task automatic upd_pulse;
    @(posedge clk_i);
    upd <= 1'b1;
    @(posedge clk_i);
    upd <= 1'b0;
    cyc(2);
  endtask : upd_pulse
  task automatic chan_chk;
    rnd = $random(seed);
    r = rnd[15:12] | 4'h1;
    @(posedge clk_i);
    {pol, cpol, ref4} <= rnd[11:0];
    en <= r;
    cen <= r;
    cyc(1);
    check({oen}, {~r});
    check({out & r}, {pol & r});
    check({coen}, {~r});
    check({cout & r}, {cpol & r});
    cyc(1);
    check({out & r}, {(ref4 ^ pol) & r});
    check({cout & r}, {(~ref4 ^ cpol) & r});
  endtask : chan_chk
  ////////////////////////////////////////
  initial begin
    #(40 * 3000);
    miscompares++;
    end_of_test;
  end
  initial begin
    do_reset;
    check(main, 1'b0);
    check(dready, 1'b1);
    rd_chk(tbo_pkg::ADDR_BDT, 16'h0000);
    rd_chk(8'h10, 16'h0000);
    wr_reg(tbo_pkg::ADDR_DCTRL, 16'hFFFF);
    rd_chk(tbo_pkg::ADDR_DCTRL, 16'h1F1F);
    i_dma.set_brk(1'b0);
    wr_reg(tbo_pkg::ADDR_BDT, 16'h8800);
    cyc(6);
    check(main, 1'b1);
    chan_chk;
    wr_reg(tbo_pkg::ADDR_BDT, 16'h0000);
    cyc(2);
    check({oen, coen}, 8'hFF);
    // burst on break_deadtime_control, one beat per burst
    wr_reg(tbo_pkg::ADDR_DCTRL, 16'h0011);
    i_dma.slow = 1'b1;
    i_dma.push(16'h8800);
    bdt_wr(16'h8800);
    drain;
    rd_chk(tbo_pkg::ADDR_BDT, m_bdt);
    rd_chk(tbo_pkg::ADDR_BURST, m_bdt);
    check(main, 1'b1);
    // byte mode over two targets, first one unmapped
    @(posedge clk_i);
    bmode <= 1'b1;
    wr_reg(tbo_pkg::ADDR_DCTRL, 16'h0110);
    i_dma.push(16'h12AB);
    bdt_wr(16'h00AB);
    drain;
    rd_chk(tbo_pkg::ADDR_BDT, m_bdt);
    @(posedge clk_i);
    bmode <= 1'b0;
    wr_reg(tbo_pkg::ADDR_DCTRL, 16'h0000);
    i_dma.slow = 1'b0;
    // register writes stall the drain so the buffer fills
    fork
      begin
        @(posedge clk_i);
        addr <= 8'h10;
        wr <= 1'b1;
        repeat (30) @(posedge clk_i);
        wr <= 1'b0;
      end
      begin
        cyc(3);
        repeat (20) begin
          rnd = $random(seed);
          i_dma.push(rnd[15:0]);
        end
        cyc(22);
        check(dready, 1'b0);
      end
    join
    drain;
    check(dready, 1'b1);
    rd_chk(tbo_pkg::ADDR_BDT, m_bdt);
    // high-active break with lock level one
    do_reset;
    // the pin filter restarts at level 1; let the low pin settle before arming
    cyc(4);
    wr_reg(tbo_pkg::ADDR_BDT, 16'hF100);
    cyc(7);
    check(main, 1'b1);
    i_dma.set_brk(1'b1);
    cyc(6);
    check(main, 1'b0);
    m_bdt[15] = 1'b0;
    upd_pulse;
    check(main, 1'b0);
    i_dma.set_brk(1'b0);
    cyc(6);
    upd_pulse;
    check(main, 1'b1);
    m_bdt[15] = 1'b1;
    wr_reg(tbo_pkg::ADDR_BDT, 16'h8200);
    rd_chk(tbo_pkg::ADDR_BDT, m_bdt);
    // idle off-state under lock one: main enable off, enabled channels hold polarity
    wr_reg(tbo_pkg::ADDR_BDT, 16'h0400);
    cyc(2);
    check({oen}, {~en});
    check({coen}, {~cen});
    check({out & en}, {pol & en});
    check(main, 1'b0);
    rd_chk(tbo_pkg::ADDR_BDT, m_bdt);
    end_of_test;
  end
endmodule : tbo_break_burst_tb_top
